// file: hdl/settings_store.v
// Saves the working register set into the user page and reloads it, with checksum.
// Assumes a command decoder on the same clock and an EEPROM that answers with done.
`timescale 1ns/1ps
`include "settings_store_consts.vh"
module settings_store (
   input  wire        core_clk,
   input  wire        rst,
   input  wire        cmd_valid,
   input  wire [7:0]  cmd_code,
   input  wire [7:0]  cmd_data,
   input  wire [7:0]  set_wdata,
   input  wire [3:0]  set_widx,
   input  wire        set_we,
   input  wire        ee_done,
   input  wire [7:0]  ee_rdata,
   output reg         ee_erase,
   output reg         ee_write,
   output reg         ee_read,
   output reg  [3:0]  ee_page,
   output reg  [4:0]  ee_addr,
   output reg  [7:0]  ee_wdata,
   output reg  [7:0]  rsp_data,
   output reg         rsp_valid,
   output reg  [7:0]  status_reg,
   output reg         busy_reg,
   output reg  [127:0] settings_flat
);
   // ------------------------------------------------------------
   // State codes
   // ------------------------------------------------------------
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_ERASE = 3'h1;
   localparam [2:0] S_PROG  = 3'h2;
   localparam [2:0] S_SUM   = 3'h3;
   localparam [2:0] S_LOAD  = 3'h4;
   localparam [2:0] S_CHECK = 3'h5;
   localparam [2:0] S_WAIT  = 3'h6;

   reg [2:0]  state_reg;
   reg [3:0]  idx_reg;
   reg [7:0]  sum_reg;
   reg [7:0]  dl_sum_reg;
   reg [7:0]  regs_reg [0:15];
   reg [7:0]  password_reg;
   reg        pw_ok_once_reg;
   reg        unlocked_reg;
   reg        pw_change_reg;
   reg        req_pending_reg;
   wire [7:0] sum_next;
   wire [7:0] sum_src;
   wire [7:0] cnt_data;

   // ------------------------------------------------------------
   // Shared ones counter: register value on store, EEPROM byte on load
   // ------------------------------------------------------------
   assign cnt_data = (state_reg == S_LOAD) ? ee_rdata : regs_reg[idx_reg];
   assign sum_src  = sum_reg;
   ones_counter u_cnt (
      .sum_in  (sum_src),
      .data_in (cnt_data),
      .sum_out (sum_next)
   );

   // Flatten working registers for the rest of the device
   integer k;
   always @(posedge core_clk) begin
      for (k = 0; k < `NUM_REGS; k = k + 1)
         settings_flat[k*8 +: 8] <= regs_reg[k];
   end

   // ------------------------------------------------------------
   // Password, sequencer and register file
   // ------------------------------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         state_reg       <= S_LOAD;            // power-up download
         idx_reg         <= 4'h0;
         sum_reg         <= 8'h00;
         dl_sum_reg      <= 8'h00;
         password_reg    <= `PASSWORD_DEFAULT;
         pw_ok_once_reg  <= 1'b0;
         unlocked_reg    <= 1'b0;
         pw_change_reg   <= 1'b0;
         req_pending_reg <= 1'b1;
         ee_erase        <= 1'b0;
         ee_write        <= 1'b0;
         ee_read         <= 1'b0;
         ee_page         <= `PAGE_USER;
         ee_addr         <= 5'h00;
         ee_wdata        <= 8'h00;
         rsp_data        <= 8'h00;
         rsp_valid       <= 1'b0;
         status_reg      <= 8'h00;
         busy_reg        <= 1'b1;
      end else begin
         rsp_valid <= 1'b0;
         ee_erase  <= 1'b0;
         ee_write  <= 1'b0;
         ee_read   <= 1'b0;
         ee_page   <= `PAGE_USER;              // factory page never addressed
         status_reg[`STATUS_UNLOCK_BIT] <= unlocked_reg;
         // Direct register writes from the device when idle
         if (set_we && state_reg == S_IDLE)
            regs_reg[set_widx] <= set_wdata;
         // Commands accepted only when idle
         if (cmd_valid && state_reg == S_IDLE) begin
            case (cmd_code)
               `CMD_PASSWORD: begin
                  if (pw_change_reg) begin
                     password_reg  <= cmd_data;    // second write after unlock sets new one
                     pw_change_reg <= 1'b0;
                     pw_ok_once_reg <= 1'b0;
                  end else if (cmd_data == password_reg) begin
                     if (pw_ok_once_reg || unlocked_reg) begin
                        unlocked_reg  <= 1'b1;
                        pw_change_reg <= unlocked_reg;
                     end
                     pw_ok_once_reg <= 1'b1;
                  end else begin
                     unlocked_reg   <= 1'b0;
                     pw_ok_once_reg <= 1'b0;
                  end
               end
               `CMD_STORE_USER: begin
                  pw_ok_once_reg <= 1'b0;
                  if (unlocked_reg) begin
                     state_reg <= S_ERASE;
                     ee_erase  <= 1'b1;            // erase first
                     busy_reg  <= 1'b1;
                  end
               end
               `CMD_RESTORE_USER: begin
                  pw_ok_once_reg <= 1'b0;
                  state_reg <= S_LOAD;
                  req_pending_reg <= 1'b1;
                  busy_reg  <= 1'b1;
                  idx_reg   <= 4'h0;
                  sum_reg   <= 8'h00;
               end
               `CMD_READ_CHECKSUM: begin
                  pw_ok_once_reg <= 1'b0;
                  rsp_data  <= dl_sum_reg;
                  rsp_valid <= 1'b1;
               end
               default: pw_ok_once_reg <= 1'b0;
            endcase
         end
         case (state_reg)
            // Busy already fell on the way into idle; a command above may raise it again
            S_IDLE: ee_page <= `PAGE_USER;
            S_ERASE: begin
               if (ee_done) begin
                  state_reg <= S_PROG;
                  idx_reg   <= 4'h0;
                  sum_reg   <= 8'h00;
                  ee_write  <= 1'b1;
                  ee_addr   <= 5'h00;
                  ee_wdata  <= regs_reg[0];
               end
            end
            S_PROG: begin
               if (ee_done) begin
                  sum_reg <= sum_next;
                  if (idx_reg == `LAST_REG_IDX) begin
                     state_reg <= S_SUM;
                     ee_write  <= 1'b1;
                     ee_addr   <= `CKSUM_ADDR;
                     ee_wdata  <= sum_next;        // checksum as last byte
                  end else begin
                     idx_reg  <= idx_reg + 4'h1;
                     ee_write <= 1'b1;
                     ee_addr  <= {1'b0, idx_reg + 4'h1};
                     ee_wdata <= regs_reg[idx_reg + 4'h1];
                  end
               end
            end
            S_SUM: begin
               if (ee_done) begin
                  state_reg <= S_IDLE;
                  busy_reg  <= 1'b0;
               end
            end
            S_LOAD: begin
               if (req_pending_reg) begin
                  req_pending_reg <= 1'b0;
                  ee_read <= 1'b1;
                  ee_addr <= {1'b0, idx_reg};
               end else if (ee_done) begin
                  regs_reg[idx_reg] <= ee_rdata;
                  sum_reg <= sum_next;
                  if (idx_reg == `LAST_REG_IDX) begin
                     state_reg <= S_CHECK;
                     ee_read   <= 1'b1;
                     ee_addr   <= `CKSUM_ADDR;
                  end else begin
                     idx_reg <= idx_reg + 4'h1;
                     ee_read <= 1'b1;
                     ee_addr <= {1'b0, idx_reg + 4'h1};
                  end
               end
            end
            S_CHECK: begin
               if (ee_done) begin
                  dl_sum_reg <= sum_reg;
                  status_reg[`STATUS_CRC_BIT] <= (ee_rdata != sum_reg);
                  state_reg <= S_IDLE;
                  busy_reg  <= 1'b0;
               end
            end
            default: begin
               state_reg <= S_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end
endmodule // settings_store

// file: hdl/settings_store_consts.vh
// Constants for the user-settings store and reload engine.
// Assumes a byte-wide command port and a simple page-addressed EEPROM port.
`ifndef SETTINGS_STORE_CONSTS_VH
`define SETTINGS_STORE_CONSTS_VH
`define CMD_STORE_USER       8'h15
`define CMD_RESTORE_USER     8'h16
`define CMD_READ_CHECKSUM    8'hd1
`define CMD_PASSWORD         8'hd5
`define PASSWORD_DEFAULT     8'hff
`define PAGE_FACTORY         4'h0
`define PAGE_USER            4'h1
`define NUM_REGS             16
`define REG_IDX_W            4
`define LAST_REG_IDX         4'hf
`define CKSUM_ADDR           5'h10
`define STATUS_CRC_BIT       1
`define STATUS_UNLOCK_BIT    4
`define STORE_TIME_MS        35
`define CLK_HZ               50000000
`define STORE_CYCLES         ((`STORE_TIME_MS * `CLK_HZ) / 1000)
`endif

// file: hdl/ones_counter.v
// Counts the one bits of a byte and adds them to an 8-bit wrapping sum.
// Assumes a purely combinational use by the store engine.
`timescale 1ns/1ps
module ones_counter (
   input  wire [7:0] sum_in,
   input  wire [7:0] data_in,
   output wire [7:0] sum_out
);
   // ------------------------------------------------------------
   // Population count
   // ------------------------------------------------------------
   wire [3:0] part [0:8];
   assign part[0] = 4'h0;
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         assign part[i+1] = part[i] + {3'h0, data_in[i]};
      end
   endgenerate
   // Sum wraps modulo 256
   assign sum_out = sum_in + {4'h0, part[8]};
endmodule // ones_counter

// file: testbench/settings_store_sva.sv
// Port checker for the settings store engine.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module settings_store_sva (
   input wire       core_clk,
   input wire       rst,
   input wire       cmd_valid,
   input wire [7:0] cmd_code,
   input wire       ee_done,
   input wire       ee_erase,
   input wire       ee_write,
   input wire       ee_read,
   input wire [3:0] ee_page,
   input wire [4:0] ee_addr,
   input wire       rsp_valid,
   input wire [7:0] status_reg,
   input wire       busy_reg
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire take = cmd_valid && !busy_reg;
   reg  erasing_reg;
   // Marks an erase still waiting for its done
   always @(posedge core_clk)
      erasing_reg <= rst ? 1'b0 : ee_erase ? 1'b1 : ee_done ? 1'b0 : erasing_reg;
   sequence store_cmd; take && cmd_code == 8'h15 && !$past(cmd_valid); endsequence
   sequence erase_end; erasing_reg && ee_done; endsequence
   AST_PAGE: assert property ((ee_erase || ee_write || ee_read) |-> ee_page == 4'h1)
      else $error("page not user");
   AST_ERASE: assert property (store_cmd and status_reg[4] |=> ee_erase)
      else $error("no erase");
   AST_LOCKED: assert property (store_cmd and !status_reg[4] |=> !ee_erase && !busy_reg)
      else $error("erase while locked");
   AST_FIRST: assert property (erase_end |=> ee_write && ee_addr == 5'h00)
      else $error("no write after erase");
   AST_NEXT: assert property (ee_done && busy_reg && !erasing_reg && ee_addr != 5'h10
      |=> ee_write || ee_read)
      else $error("sequence stalled");
   AST_IDLE: assert property (ee_done && busy_reg && !erasing_reg && ee_addr == 5'h10
      |-> ##[1:3] !busy_reg)
      else $error("no idle");
   AST_BOOT: assert property ($fell(rst) |-> ##[0:1] (ee_read && ee_addr == 5'h00))
      else $error("no boot read");
   AST_RESTORE: assert property (take && cmd_code == 8'h16
      |-> ##[1:2] (ee_read && ee_addr == 5'h00))
      else $error("no restore read");
   AST_RSP: assert property (take && cmd_code == 8'hd1 |=> rsp_valid)
      else $error("no checksum answer");
endmodule // settings_store_sva
bind settings_store settings_store_sva i_sva (.core_clk(core_clk), .rst(rst),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code), .ee_done(ee_done), .ee_erase(ee_erase),
   .ee_write(ee_write), .ee_read(ee_read), .ee_page(ee_page), .ee_addr(ee_addr),
   .rsp_valid(rsp_valid), .status_reg(status_reg), .busy_reg(busy_reg));

// file: testbench/eeprom_model.sv
// EEPROM user-page model: erase, byte write, byte read.
// Assumes one-cycle request pulses from the engine.
`timescale 1ns/1ps
module eeprom_model (
   input  wire       core_clk,
   input  wire       slow,
   input  wire       ee_erase,
   input  wire       ee_write,
   input  wire       ee_read,
   input  wire [3:0] ee_page,
   input  wire [4:0] ee_addr,
   input  wire [7:0] ee_wdata,
   output reg        ee_done,
   output reg  [7:0] ee_rdata
);
   reg [7:0] mem [0:16];
   reg [3:0] wait_reg = 4'h0;
   reg [7:0] hold_reg = 8'h00;
   integer   i;
   initial for (i = 0; i < 17; i = i + 1) mem[i] = 8'h00;
   initial ee_done = 1'b0;
   initial ee_rdata = 8'h00;
   // Act at once, answer done after a prompt or slow delay
   always @(posedge core_clk) begin
      ee_done <= 1'b0;
      ee_rdata <= ~ee_rdata; // Data is not held between answers
      if (wait_reg == 4'h1) begin
         ee_done <= 1'b1;
         ee_rdata <= hold_reg;
      end
      if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
      if (ee_erase || ee_write || ee_read) wait_reg <= slow ? 4'h9 : 4'h1;
      if (ee_page == 4'h1 && ee_erase) for (i = 0; i < 17; i = i + 1) mem[i] <= 8'hff;
      if (ee_page == 4'h1 && ee_write) mem[ee_addr] <= ee_wdata;
      if (ee_read) hold_reg <= mem[ee_addr];
   end
endmodule // eeprom_model

// file: testbench/settings_store_tb.sv
// Self-checking bench for the settings store engine.
// Assumes the EEPROM model and the bound checker.
`timescale 1ns/1ps
module settings_store_tb;
   reg          core_clk, rst, cmd_valid, set_we, slow;
   reg  [7:0]   cmd_code, cmd_data, set_wdata, sum, got;
   reg  [3:0]   set_widx;
   wire         ee_done, ee_erase, ee_write, ee_read, rsp_valid, busy_reg;
   wire [7:0]   ee_rdata, ee_wdata, rsp_data, status_reg;
   wire [3:0]   ee_page;
   wire [4:0]   ee_addr;
   wire [127:0] settings_flat;
   reg  [127:0] flat;
   integer      errors, tests_run, k, n;
   settings_store i_dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_data(cmd_data), .set_wdata(set_wdata), .set_widx(set_widx),
      .set_we(set_we), .ee_done(ee_done), .ee_rdata(ee_rdata), .ee_erase(ee_erase),
      .ee_write(ee_write), .ee_read(ee_read), .ee_page(ee_page), .ee_addr(ee_addr),
      .ee_wdata(ee_wdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
      .status_reg(status_reg), .busy_reg(busy_reg), .settings_flat(settings_flat));
   eeprom_model i_mem (.core_clk(core_clk), .slow(slow), .ee_erase(ee_erase),
      .ee_write(ee_write), .ee_read(ee_read), .ee_page(ee_page), .ee_addr(ee_addr),
      .ee_wdata(ee_wdata), .ee_done(ee_done), .ee_rdata(ee_rdata));
   // Clock and watchdog
   initial begin core_clk = 1'b0; forever #10 core_clk = ~core_clk; end
   initial begin #400000; errors = errors + 1; stop_test; end
   function [7:0] ones(input [7:0] b); integer j;
      begin ones = 0; for (j = 0; j < 8; j = j + 1) ones = ones + b[j]; end endfunction
   function [7:0] val(input integer i); val = i * 29 + 7; endfunction
   task tick; begin @(posedge core_clk); #1; end endtask
   task idle; begin tick; tick;
      for (n = 0; n < 500 && busy_reg !== 1'b0; n = n + 1) tick;
      chk("busy", 1'b0, busy_reg);
      end endtask
   task send(input [7:0] c, input [7:0] d); begin
      @(posedge core_clk) cmd_valid <= 1'b1; cmd_code <= c; cmd_data <= d;
      @(posedge core_clk) cmd_valid <= 1'b0; #1; end endtask
   task wr(input [3:0] i, input [7:0] d); begin
      @(posedge core_clk) set_we <= 1'b1; set_widx <= i; set_wdata <= d;
      @(posedge core_clk) set_we <= 1'b0; end endtask
   task rdsum; begin send(8'hd1, 8'h00);
      for (n = 0; n < 4 && rsp_valid !== 1'b1; n = n + 1) tick;
      chk("answer", 1'b1, rsp_valid);
      got = rsp_data; end endtask
   task chk(input string nm, input [127:0] e, input [127:0] g); begin
      tests_run = tests_run + 1;
      if (g !== e) begin errors = errors + 1;
         $display("ERROR %s expected %h seen %h", nm, e, g); end end endtask
   task t_locked; begin
      for (k = 0; k < 16; k = k + 1) wr(k, val(k));
      send(8'h15, 8'h00); idle;
      chk("cell0", 8'h00, i_mem.mem[0]);
      $display("locked store done"); end endtask
   task t_store; begin
      send(8'hd5, 8'hff); send(8'hd5, 8'hff); tick;
      chk("unlocked", 1'b1, status_reg[4]);
      slow <= 1'b1; send(8'h15, 8'h00); idle; slow <= 1'b0;
      sum = 0;
      for (k = 0; k < 16; k = k + 1) begin sum = sum + ones(val(k));
         flat[k*8+:8] = val(k); chk("cell", val(k), i_mem.mem[k]); end
      chk("stored sum", sum, i_mem.mem[16]);
      $display("store done"); end endtask
   task t_restore; begin
      wr(0, 8'h00); send(8'h16, 8'h00); idle;
      chk("regs", flat, settings_flat);
      rdsum; chk("sum", sum, got);
      chk("fault", 1'b0, status_reg[1]);
      $display("restore done"); end endtask
   task t_relock; begin
      send(8'hd5, 8'h00); tick; chk("unlocked", 1'b0, status_reg[4]);
      wr(0, 8'h00); send(8'h15, 8'h00); idle;
      chk("cell0", val(0), i_mem.mem[0]);
      $display("relock done"); end endtask
   task t_power; begin
      @(posedge core_clk) rst <= 1'b1; repeat (3) tick;
      @(posedge core_clk) rst <= 1'b0; idle;
      chk("regs", flat, settings_flat);
      $display("power cycle done"); end endtask
   task t_fault; begin
      i_mem.mem[3] = i_mem.mem[3] ^ 8'h01; sum = 0;
      for (k = 0; k < 16; k = k + 1) sum = sum + ones(i_mem.mem[k]);
      send(8'h16, 8'h00); idle;
      chk("fault", 1'b1, status_reg[1]);
      rdsum; chk("sum", sum, got);
      $display("fault done"); end endtask
   // Unlock, change the password, then only the new one unlocks
   task t_passwd; begin
      send(8'hd5, 8'hff); send(8'hd5, 8'hff); send(8'hd5, 8'hff); send(8'hd5, 8'h5a);
      send(8'hd5, 8'h00); send(8'hd5, 8'hff); send(8'hd5, 8'hff); tick;
      chk("old password", 1'b0, status_reg[4]);
      send(8'hd5, 8'h5a); send(8'hd5, 8'h5a); tick;
      chk("new password", 1'b1, status_reg[4]);
      $display("password change done"); end endtask
   task stop_test; begin
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish; end endtask
   // Reset, then the scenarios
   initial begin
      errors = 0; tests_run = 0; rst = 1'b1; cmd_valid = 1'b0; cmd_code = 8'h00;
      cmd_data = 8'h00; set_we = 1'b0; set_widx = 4'h0; set_wdata = 8'h00; slow = 1'b0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0; idle;
      t_locked; t_store; t_restore; t_relock; t_power; t_fault; t_passwd;
      stop_test;
   end
endmodule // settings_store_tb
